/* design/pdhp_host.sv */
// host-side controller driving the parallel converter pins
// Operation
// - 16-bit two-way data bus, bit 15 MSB
// - select active low frames each access
// - write: direction low, select low 20 ns
// - read: direction high, select low 40 ns
// - select high 80 ns between accesses
// - load rise 10 ns after write select fall
// - wait 50 ns after load before select
// - load low and high phases 40 ns
// - hold reset level 20 ns after rise
// - output reset phases 40 ns each
// - tied mode: select, direction low, pulse load
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/100ps
module pdhp_host (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic sel_n_o,
    output logic dir_o,
    output logic load_strobe_o,
    output logic out_reset_o,
    output logic reset_level_select_o,
    output logic code_format_select_o,
    output logic powerdown_sel0_o,
    output logic powerdown_sel1_o,
    input wire logic [15:0] data_bus_i,
    output logic [15:0] data_bus_o,
    output logic [15:0] data_bus_oe_o
);
    pdhp_pkg::pdhp_state_s_t s_r;
    pdhp_pkg::pdhp_state_s_t s_nxt;

    function automatic logic [7:0] cyc8(input int n);
        return n[7:0];
    endfunction

    logic req;
    logic busy;
    assign req = wb_cyc_i && wb_stb_i && !s_r.wb.ack;
    assign busy = (s_r.st != pdhp_pkg::PDHP_IDLE) || (s_r.cmd != 4'h0);

    always_comb begin
        s_nxt = s_r;
        s_nxt.wb.ack = 1'b0;
        // second flop only reads first flop
        s_nxt.din_s1 = data_bus_i;
        s_nxt.din_s2 = s_r.din_s1;
        if (s_r.gap != 8'h00) begin
            s_nxt.gap = s_r.gap - 8'h01;
        end
        if (req) begin
            s_nxt.wb.ack = 1'b1;
            s_nxt.wb.dat = 32'h0000_0000;
            case (wb_adr_i)
                pdhp_pkg::REG_CTRL: begin
                    s_nxt.wb.dat = {27'h000_0000, s_r.ctrl};
                    if (wb_we_i && wb_sel_i[0]) begin
                        s_nxt.ctrl = wb_dat_i[4:0];
                    end
                end
                pdhp_pkg::REG_WDATA: begin
                    s_nxt.wb.dat = {16'h0000, s_r.wdata};
                    if (wb_we_i && wb_sel_i[0]) begin
                        s_nxt.wdata[7:0] = wb_dat_i[7:0];
                    end
                    if (wb_we_i && wb_sel_i[1]) begin
                        s_nxt.wdata[15:8] = wb_dat_i[15:8];
                    end
                end
                pdhp_pkg::REG_CMD: begin
                    // commands while busy are dropped
                    if (wb_we_i && wb_sel_i[0] && !busy) begin
                        s_nxt.cmd = wb_dat_i[3:0];
                    end
                end
                pdhp_pkg::REG_STAT: begin
                    s_nxt.wb.dat = {s_r.rdata, 14'h0000, s_r.rd_done, busy};
                end
                default: begin
                    s_nxt.wb.dat = 32'h0000_0000;
                end
            endcase
        end
        if (s_r.cnt != 8'h00) begin
            s_nxt.cnt = s_r.cnt - 8'h01;
        end
        case (s_r.st)
            pdhp_pkg::PDHP_IDLE: begin
                s_nxt.pins.dout = s_r.wdata;
                if (s_r.ctrl[pdhp_pkg::CTRL_TIED]) begin
                    // tied mode: select and direction held low
                    s_nxt.pins.sel_n = 1'b0;
                    s_nxt.pins.dir = 1'b0;
                    s_nxt.pins.dout_oe = 1'b1;
                end else begin
                    s_nxt.pins.sel_n = 1'b1;
                    s_nxt.pins.dout_oe = 1'b0;
                end
                if (s_r.cmd[pdhp_pkg::CMD_WRITE] && s_r.gap == 8'h00) begin
                    s_nxt.cmd[pdhp_pkg::CMD_WRITE] = 1'b0;
                    s_nxt.pins.dir = 1'b0;
                    s_nxt.pins.dout_oe = 1'b1;
                    if (s_r.ctrl[pdhp_pkg::CTRL_TIED]) begin
                        // data change in tied mode is the write
                        s_nxt.cnt = cyc8(pdhp_pkg::C_LOAD_SETUP);
                        s_nxt.st = pdhp_pkg::PDHP_LD_WAIT;
                    end else begin
                        // select falls with data already stable
                        s_nxt.pins.sel_n = 1'b0;
                        s_nxt.cnt = cyc8(pdhp_pkg::C_WR_LOW);
                        s_nxt.st = pdhp_pkg::PDHP_WR;
                    end
                end else if (s_r.cmd[pdhp_pkg::CMD_READ] && s_r.gap == 8'h00
                        && !s_r.ctrl[pdhp_pkg::CTRL_TIED]) begin
                    s_nxt.cmd[pdhp_pkg::CMD_READ] = 1'b0;
                    s_nxt.pins.dir = 1'b1;
                    s_nxt.pins.dout_oe = 1'b0;
                    s_nxt.rd_done = 1'b0;
                    s_nxt.cnt = cyc8(pdhp_pkg::C_DIR_SETUP);
                    s_nxt.st = pdhp_pkg::PDHP_RD_SETUP;
                end else if (s_r.cmd[pdhp_pkg::CMD_READ]) begin
                    s_nxt.cmd[pdhp_pkg::CMD_READ] = s_r.ctrl[pdhp_pkg::CTRL_TIED]
                        ? 1'b0 : 1'b1;
                end else if (s_r.cmd[pdhp_pkg::CMD_LOAD] && s_r.gap == 8'h00) begin
                    // load works whether or not select is low
                    s_nxt.cmd[pdhp_pkg::CMD_LOAD] = 1'b0;
                    // only after the write and its gap are over
                    s_nxt.pins.load = 1'b1;
                    s_nxt.cnt = cyc8(pdhp_pkg::C_LOAD_PHASE);
                    s_nxt.st = pdhp_pkg::PDHP_LD_HI;
                end else if (s_r.cmd[pdhp_pkg::CMD_ORST]) begin
                    s_nxt.cmd[pdhp_pkg::CMD_ORST] = 1'b0;
                    s_nxt.pins.orst = 1'b1;
                    s_nxt.cnt = cyc8(pdhp_pkg::C_RST_PHASE);
                    s_nxt.st = pdhp_pkg::PDHP_RS_HI;
                end
            end
            pdhp_pkg::PDHP_WR: begin
                // select low at least the write width
                if (s_r.cnt == 8'h01) begin
                    s_nxt.pins.sel_n = 1'b1;
                    s_nxt.cnt = cyc8(pdhp_pkg::C_DATA_HOLD);
                    s_nxt.st = pdhp_pkg::PDHP_HOLD;
                end
            end
            pdhp_pkg::PDHP_RD_SETUP: begin
                if (s_r.cnt == 8'h01) begin
                    s_nxt.pins.sel_n = 1'b0;
                    s_nxt.cnt = cyc8(pdhp_pkg::C_RD_LOW);
                    s_nxt.st = pdhp_pkg::PDHP_RD;
                end
            end
            pdhp_pkg::PDHP_RD: begin
                // sample after the read width plus sync delay
                if (s_r.cnt == 8'h01) begin
                    s_nxt.rdata = s_r.din_s2;
                    s_nxt.rd_done = 1'b1;
                    s_nxt.pins.sel_n = 1'b1;
                    s_nxt.cnt = cyc8(pdhp_pkg::C_DATA_HOLD);
                    s_nxt.st = pdhp_pkg::PDHP_HOLD;
                end
            end
            pdhp_pkg::PDHP_HOLD: begin
                // direction and data held past select rise
                if (s_r.cnt == 8'h01) begin
                    s_nxt.pins.dout_oe = 1'b0;
                    s_nxt.pins.dir = 1'b0;
                    s_nxt.gap = cyc8(pdhp_pkg::C_SEL_HIGH);
                    s_nxt.st = pdhp_pkg::PDHP_IDLE;
                end
            end
            pdhp_pkg::PDHP_LD_WAIT: begin
                if (s_r.cnt == 8'h01) begin
                    s_nxt.st = pdhp_pkg::PDHP_IDLE;
                end
            end
            pdhp_pkg::PDHP_LD_HI: begin
                if (s_r.cnt == 8'h01) begin
                    s_nxt.pins.load = 1'b0;
                    s_nxt.cnt = cyc8(pdhp_pkg::C_LOAD_PHASE);
                    s_nxt.st = pdhp_pkg::PDHP_LD_LO;
                end
            end
            pdhp_pkg::PDHP_RS_HI: begin
                // high phase covers the level hold too
                if (s_r.cnt == 8'h01) begin
                    s_nxt.pins.orst = 1'b0;
                    s_nxt.cnt = cyc8(pdhp_pkg::C_RST_PHASE);
                    s_nxt.st = pdhp_pkg::PDHP_RS_LO;
                end
            end
            pdhp_pkg::PDHP_LD_LO, pdhp_pkg::PDHP_RS_LO,
            pdhp_pkg::PDHP_GAP: begin
                if (s_r.cnt == 8'h01) begin
                    s_nxt.st = pdhp_pkg::PDHP_IDLE;
                end
            end
            default: begin
                s_nxt.st = pdhp_pkg::PDHP_IDLE;
            end
        endcase
        // load-to-select spacing already exceeded by low phase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r.st <= pdhp_pkg::PDHP_IDLE;
            s_r.cnt <= 8'h00;
            s_r.gap <= 8'h00;
            s_r.ctrl <= pdhp_pkg::CTRL_RESET;
            s_r.wdata <= pdhp_pkg::WDATA_RESET;
            s_r.rdata <= 16'h0000;
            s_r.cmd <= 4'h0;
            s_r.rd_done <= 1'b0;
            s_r.pins <= '{sel_n: 1'b1, dir: 1'b0, load: 1'b0, orst: 1'b0,
                dout: 16'h0000, dout_oe: 1'b0};
            s_r.wb <= '{dat: 32'h0000_0000, ack: 1'b0};
            s_r.din_s1 <= 16'h0000;
            s_r.din_s2 <= 16'h0000;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_dat_o = s_r.wb.dat;
    assign wb_ack_o = s_r.wb.ack;
    assign sel_n_o = s_r.pins.sel_n;
    assign dir_o = s_r.pins.dir;
    assign load_strobe_o = s_r.pins.load;
    assign out_reset_o = s_r.pins.orst;
    // level held steady by register while reset strobe runs
    assign reset_level_select_o = s_r.ctrl[pdhp_pkg::CTRL_RSEL];
    assign code_format_select_o = s_r.ctrl[pdhp_pkg::CTRL_FMT];
    assign powerdown_sel0_o = s_r.ctrl[pdhp_pkg::CTRL_PD0];
    assign powerdown_sel1_o = s_r.ctrl[pdhp_pkg::CTRL_PD1];
    assign data_bus_o = s_r.pins.dout;
    assign data_bus_oe_o = {16{s_r.pins.dout_oe}};
endmodule // pdhp_host

/* design/pdhp_pkg.sv */
// shared constants and types for the parallel converter host port
package pdhp_pkg;
    localparam int CLK_MHZ = 10;
    // pin timing in ns, cycles rounded up (least times)
    localparam int T_WR_LOW_NS = 20;
    localparam int T_RD_LOW_NS = 40;
    localparam int T_SEL_HIGH_NS = 80;
    localparam int T_LOAD_SETUP_NS = 10;
    localparam int T_LOAD_TO_SEL_NS = 50;
    localparam int T_LOAD_PHASE_NS = 40;
    localparam int T_RESET_LEVEL_SELECT_HOLD_NS = 20;
    localparam int T_RST_PHASE_NS = 40;
    localparam int T_DIR_SETUP_NS = 30;
    localparam int T_DATA_OUT_NS = 80;
    localparam int T_DATA_HOLD_NS = 15;
    function automatic int ns2cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int C_WR_LOW = ns2cyc(T_WR_LOW_NS);
    // read low time also covers data-out delay plus two sync flops
    localparam int C_RD_LOW = ns2cyc(T_RD_LOW_NS + T_DATA_OUT_NS) + 2;
    localparam int C_SEL_HIGH = ns2cyc(T_SEL_HIGH_NS);
    localparam int C_LOAD_SETUP = ns2cyc(T_LOAD_SETUP_NS);
    localparam int C_LOAD_TO_SEL = ns2cyc(T_LOAD_TO_SEL_NS);
    localparam int C_LOAD_PHASE = ns2cyc(T_LOAD_PHASE_NS);
    localparam int C_RESET_LEVEL_SELECT_HOLD = ns2cyc(T_RESET_LEVEL_SELECT_HOLD_NS);
    localparam int C_RST_PHASE = ns2cyc(T_RST_PHASE_NS);
    localparam int C_DIR_SETUP = ns2cyc(T_DIR_SETUP_NS);
    localparam int C_DATA_HOLD = ns2cyc(T_DATA_HOLD_NS);

    // register offsets (byte addresses)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_WDATA = 4'h4;
    localparam logic [3:0] REG_CMD = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hC;
    // ctrl fields
    localparam int CTRL_FMT = 0;
    localparam int CTRL_RSEL = 1;
    localparam int CTRL_PD0 = 2;
    localparam int CTRL_PD1 = 3;
    localparam int CTRL_TIED = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    // cmd fields (write one to start)
    localparam int CMD_WRITE = 0;
    localparam int CMD_READ = 1;
    localparam int CMD_LOAD = 2;
    localparam int CMD_ORST = 3;
    localparam logic [15:0] WDATA_RESET = 16'h0000;

    typedef enum {
        PDHP_IDLE, PDHP_WR, PDHP_RD_SETUP, PDHP_RD, PDHP_HOLD,
        PDHP_LD_WAIT, PDHP_LD_HI, PDHP_LD_LO, PDHP_RS_HI, PDHP_RS_LO,
        PDHP_GAP
    } pdhp_state_t;

    typedef struct packed {
        logic sel_n;
        logic dir;
        logic load;
        logic orst;
        logic [15:0] dout;
        logic dout_oe;
    } pdhp_pins_t;

    typedef struct packed {
        logic [31:0] dat;
        logic ack;
    } pdhp_wb_resp_t;

    typedef struct packed {
        pdhp_state_t st;
        logic [7:0] cnt;
        logic [7:0] gap;
        logic [4:0] ctrl;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [3:0] cmd;
        logic rd_done;
        pdhp_pins_t pins;
        pdhp_wb_resp_t wb;
        logic [15:0] din_s1;
        logic [15:0] din_s2;
    } pdhp_state_s_t;
endpackage

/* verification/pdhp_host_sva.sv */
// pin and bus checks for the converter host port
`timescale 1ns/100ps
module pdhp_host_sva (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic sel_n_o,
    input wire logic dir_o,
    input wire logic load_strobe_o,
    input wire logic out_reset_o,
    input wire logic reset_level_select_o,
    input wire logic [15:0] data_bus_o,
    input wire logic [15:0] data_bus_oe_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_wb_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("no ack one cycle after request");
    a_sel_gap: assert property ($rose(sel_n_o) |=> sel_n_o)
        else $error("select high phase too short");
    a_wr_hold: assert property ($rose(sel_n_o) && !dir_o |->
        &data_bus_oe_o && $stable(data_bus_o))
        else $error("write data not held at select rise");
    // direction must settle before the read frame opens
    a_rd_frame: assert property ($fell(sel_n_o) && dir_o |->
        $past(dir_o) ##0 (dir_o && !sel_n_o && !data_bus_oe_o[0])[*2])
        else $error("read frame too short or bus driven");
    a_dir_hold: assert property ($rose(sel_n_o) |->
        $stable(dir_o)) else $error("direction moved at select rise");
    // one 100 ns cycle already covers each 40 ns phase
    a_load_phase: assert property ($rose(load_strobe_o) |->
        load_strobe_o ##1 !load_strobe_o[*2])
        else $error("load strobe phase too short");
    a_load_sel: assert property ($rose(load_strobe_o) |->
        !$fell(sel_n_o) ##1 !$fell(sel_n_o))
        else $error("select fell too close to load strobe");
    a_rst_phase: assert property ($rose(out_reset_o) |->
        out_reset_o ##1 !out_reset_o[*2])
        else $error("output reset phase too short");
    a_rsel_hold: assert property ($rose(out_reset_o) |->
        $stable(reset_level_select_o)[*2])
        else $error("reset level moved during reset");
    c_load: cover property ($rose(load_strobe_o));
    c_read: cover property ($fell(sel_n_o) && dir_o);
    c_orst: cover property ($rose(out_reset_o));
endmodule // pdhp_host_sva
bind pdhp_host pdhp_host_sva chk (.*);

/* verification/pdhp_dev.sv */
// behavioural converter device on the far side of the pins
`timescale 1ns/100ps
module pdhp_dev (
    input wire logic sel_n_i,
    input wire logic dir_i,
    input wire logic load_i,
    input wire logic orst_i,
    input wire logic rsel_i,
    input wire logic fmt_i,
    input wire logic [1:0] pd_i,
    input wire logic [15:0] bus_i,
    output logic [15:0] bus_o,
    output logic [15:0] in_reg_o,
    output logic [15:0] conv_o,
    output logic [1:0] pd_o
);
    logic vld;
    initial begin
        vld = 1'b0;
        in_reg_o = 16'h0000;
        conv_o = 16'h0000;
    end
    // data is only valid 80 ns after select falls, not before
    always @(negedge sel_n_i) begin
        vld = 1'b0;
        #80 vld = !sel_n_i;
    end
    always @(posedge sel_n_i) vld = 1'b0;
    // released bus shows the inverse, never a stale copy
    assign bus_o = (vld && dir_i) ? in_reg_o : ~in_reg_o;
    always @(posedge sel_n_i) if (!dir_i) in_reg_o = bus_i;
    always @(posedge load_i) begin
        if (!sel_n_i && !dir_i) in_reg_o = bus_i; // tied path
        conv_o = in_reg_o;
    end
    // target flips with code format
    always @(posedge orst_i) conv_o = {rsel_i ^ fmt_i, 15'h0000};
    assign pd_o = pd_i;
endmodule // pdhp_dev

/* verification/tb.sv */
// self-checking bench for the converter host port
`timescale 1ns/100ps
module tb;
    logic clk_i, rst_i, cyc, stb, we, ack, sel_n, dir, ld, ors, rsel, fmt;
    logic [3:0] adr;
    logic [31:0] wdat, rdat, q;
    logic [15:0] hd, hoe, dd, bus, inr, conv;
    wire [1:0] pdh;
    logic [1:0] pd;
    int failures, compares, cyc_cnt;
    assign bus = hoe[0] ? hd : dd;
    pdhp_host uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sel_n_o(sel_n),
        .dir_o(dir), .load_strobe_o(ld), .out_reset_o(ors),
        .reset_level_select_o(rsel), .code_format_select_o(fmt),
        .powerdown_sel0_o(pdh[0]), .powerdown_sel1_o(pdh[1]),
        .data_bus_i(bus), .data_bus_o(hd), .data_bus_oe_o(hoe));
    pdhp_dev dev (.sel_n_i(sel_n), .dir_i(dir), .load_i(ld), .orst_i(ors),
        .rsel_i(rsel), .fmt_i(fmt), .pd_i(pdh), .bus_i(bus), .bus_o(dd),
        .in_reg_o(inr), .conv_o(conv), .pd_o(pd));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("Error %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task tally_and_finish;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // classic cycle; ack seen as sampled at the edge
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // start a command and poll busy, bounded
    task cmd(input logic [3:0] c);
        int n;
        wb(1'b1, pdhp_pkg::REG_CMD, {28'h000_0000, c});
        n = 0;
        do begin
            wb(1'b0, pdhp_pkg::REG_STAT, 32'h0000_0000);
            n++;
        end while (q[0] !== 1'b0 && n < 60);
        chk(q[0], 1'b0);
        repeat (10) @(posedge clk_i);
    endtask
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            failures++;
            tally_and_finish;
        end
    end
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, adr, wdat} = '0;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk({sel_n, dir, ld, ors, hoe[0]}, 5'b10000);
        wb(1'b0, pdhp_pkg::REG_CTRL, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        wb(1'b0, 4'h2, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        $display("test reset done");
        wb(1'b1, pdhp_pkg::REG_WDATA, 32'h0000_a5c3);
        cmd(4'h1);
        chk(inr, 16'ha5c3);
        cmd(4'h4);
        chk(conv, 16'ha5c3);
        cmd(4'h2);
        chk(q[31:16], 16'ha5c3);
        chk(q[1], 1'b1);
        $display("test write load read done");
        // all level and format pairs; input register must survive
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, pdhp_pkg::REG_CTRL, i);
            cmd(4'h8);
            chk(conv, {i[0] ^ i[1], 15'h0000});
            chk(inr, 16'ha5c3);
        end
        $display("test output reset done");
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, pdhp_pkg::REG_CTRL, i << 2);
            repeat (2) @(posedge clk_i);
            chk(pd, i[1:0]);
        end
        $display("test power down done");
        wb(1'b1, pdhp_pkg::REG_CTRL, 32'h0000_0010);
        wb(1'b1, pdhp_pkg::REG_WDATA, 32'h0000_1234);
        cmd(4'h1);
        cmd(4'h4);
        chk(conv, 16'h1234);
        chk({sel_n, dir}, 2'b00);
        cmd(4'h2);
        chk(q[31:16], 16'ha5c3);
        $display("test tied mode done");
        tally_and_finish;
    end
endmodule // tb
